// ===== src/arb_pkg.sv
// Constants and types of the ACL rule byte bank
`default_nettype none
package arb_pkg;

    // ********************************
    // Sizes
    // ********************************
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int NUM_PORTS  = 5;
    localparam int RULE_BYTES = 16;
    localparam int OFS_W      = 4;
    localparam int PIDX_W     = 3;

    // ********************************
    // Direct register offsets
    // ********************************
    localparam logic [7:0] REG_TBL_SEL   = 8'h6e;
    localparam logic [7:0] REG_BYTE_OFS  = 8'h6f;
    localparam logic [7:0] REG_BYTE_DATA = 8'ha0;

    // ********************************
    // Table-select register fields
    // ********************************
    localparam int         TBL_HI     = 7;
    localparam int         TBL_LO     = 5;
    localparam logic [2:0] TBL_ACL    = 3'h2;
    localparam int         PORT_HI    = 3;
    localparam int         PORT_LO    = 0;
    localparam logic [3:0] PORT_FIRST = 4'h1;
    localparam logic [3:0] PORT_LAST  = 4'h5;

    // ********************************
    // Rule byte offsets
    // ********************************
    localparam logic [3:0] OFS_MAX_LO  = 4'h0;
    localparam logic [3:0] OFS_MIN_HI  = 4'h1;
    localparam logic [3:0] OFS_MAX_HI  = 4'h2;
    localparam logic [3:0] OFS_MIN_LO  = 4'h3;
    localparam logic [3:0] OFS_MODE    = 4'h4;
    localparam logic [3:0] OFS_PROTO   = 4'h5;
    localparam logic [3:0] OFS_IP_MSB  = 4'h2;
    localparam logic [3:0] OFS_MSK_MSB = 4'h6;

    // ********************************
    // Rule field positions
    // ********************************
    localparam int         MODE_HI    = 2;
    localparam int         MODE_LO    = 1;
    localparam int         PROTO_TOP  = 0;
    localparam int         FME_BIT    = 0;
    localparam logic [7:0] MODE_WMASK = 8'h07;
    localparam logic [7:0] FULL_WMASK = 8'hff;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] RULE_RST  = 8'h00;
    localparam logic [7:0] SEL_RST   = 8'h00;
    localparam logic [7:0] OFS_RST   = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        CMP_OFF     = 2'h0,
        CMP_EITHER  = 2'h1,
        CMP_INSIDE  = 2'h2,
        CMP_OUTSIDE = 2'h3
    } arb_cmp_mode_t;

    typedef struct packed {
        logic [31:0]   rule_ip_address;
        logic [31:0]   rule_ip_bitmask;
        logic [15:0]   max_port;
        logic [15:0]   min_port;
        arb_cmp_mode_t mode;
        logic [7:0]    proto;
        logic          tcp_flag_match_enable;
    } arb_rule_t;

    typedef struct packed {
        logic [31:0] ip;
        logic [15:0] l4_port;
    } arb_pkt_t;

    typedef struct packed {
        logic l3;
        logic l4;
    } arb_match_t;

endpackage : arb_pkg
`default_nettype wire

// ===== src/arb_match_unit.sv
// Layer 3 and Layer 4 comparison for one port's rule
`timescale 1ns/1ps
`default_nettype none
module arb_match_unit (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire arb_pkg::arb_rule_t rule,
    input  wire arb_pkg::arb_pkt_t  pkt,
    output arb_pkg::arb_match_t     match
);
    import arb_pkg::*;

    logic       l3_hit;
    logic       in_range;
    logic       on_bound;
    logic       l4_hit;
    arb_match_t match_reg;

    // ********************************
    // Comparators
    // ********************************
    assign l3_hit = ((pkt.ip ^ rule.rule_ip_address) & rule.rule_ip_bitmask) == '0;
    assign on_bound = (pkt.l4_port == rule.max_port) ||
                      (pkt.l4_port == rule.min_port);
    assign in_range = (pkt.l4_port >= rule.min_port) &&
                      (pkt.l4_port <= rule.max_port);

    always_comb begin
        case (rule.mode)
            CMP_OFF:     l4_hit = 1'b0;
            CMP_EITHER:  l4_hit = on_bound;
            CMP_INSIDE:  l4_hit = in_range;
            CMP_OUTSIDE: l4_hit = !in_range;
            default:     l4_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_reg <= '0;
        end else begin
            match_reg.l3 <= l3_hit;
            match_reg.l4 <= l4_hit;
        end
    end

    assign match = match_reg;

    // ********************************
    // Checks
    // ********************************
    property p_l3_mask;
        @(posedge clk) disable iff (!rst_n)
        (rule.rule_ip_bitmask == '0) |=> match.l3;
    endproperty
    a_l3_mask: assert property (p_l3_mask)
        else $error("zero mask must give a layer 3 match");

    property p_l4_mode;
        @(posedge clk) disable iff (!rst_n)
        (rule.mode == CMP_OUTSIDE && pkt.l4_port < rule.min_port)
            |=> match.l4;
    endproperty
    a_l4_mode: assert property (p_l4_mode)
        else $error("port below range must match outside mode");

endmodule : arb_match_unit
`default_nettype wire

// ===== src/arb_bank.sv
// Indirectly reached per-port ACL rule byte bank with match outputs
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module arb_bank (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [7:0]                bus_addr,
    input  wire logic [7:0]                bus_wdata,
    input  wire logic                      bus_wr,
    input  wire logic                      bus_rd,
    output logic [7:0]                     bus_rdata,
    input  wire arb_pkg::arb_pkt_t         pkt,
    output arb_pkg::arb_rule_t [4:0]       rule_out,
    output arb_pkg::arb_match_t [4:0]      match_out
);
    import arb_pkg::*;

    // ********************************
    // Storage
    // ********************************
    logic [7:0] sel_reg;
    logic [7:0] sel_next;
    logic [7:0] ofs_reg;
    logic [7:0] ofs_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] rule_mem [NUM_PORTS][RULE_BYTES];

    // ********************************
    // Decode
    // ********************************
    logic              tbl_hit;
    logic [3:0]        port_num;
    logic              port_ok;
    logic              ofs_ok;
    logic              ind_ok;
    logic [PIDX_W-1:0] port_idx;
    logic [OFS_W-1:0]  ofs_idx;
    logic [7:0]        cur_byte;
    logic [7:0]        wr_byte;
    logic              wr_sel;
    logic              wr_ofs;
    logic              wr_data;
    logic [7:0]        rd_mux;

    // Writable bits of one rule byte
    function automatic logic [7:0] rw_mask(input logic [OFS_W-1:0] ofs);
        rw_mask = (ofs == OFS_MODE) ? MODE_WMASK : FULL_WMASK;
    endfunction : rw_mask

    assign tbl_hit  = sel_reg[TBL_HI:TBL_LO] == TBL_ACL;
    assign port_num = sel_reg[PORT_HI:PORT_LO];
    assign port_ok  = (port_num >= PORT_FIRST) &&
                      (port_num <= PORT_LAST);
    assign ofs_ok   = ofs_reg[ADDR_W-1:OFS_W] == '0;
    assign ind_ok   = tbl_hit && port_ok && ofs_ok;
    assign port_idx = PIDX_W'(port_num - PORT_FIRST);
    assign ofs_idx  = ofs_reg[OFS_W-1:0];

    // Out-of-window accesses read zero
    assign cur_byte = ind_ok ?
                      (rule_mem[port_idx][ofs_idx] & rw_mask(ofs_idx)) :
                      8'h00;
    assign wr_byte  = bus_wdata & rw_mask(ofs_idx);

    assign wr_sel  = bus_wr && (bus_addr == REG_TBL_SEL);
    assign wr_ofs  = bus_wr && (bus_addr == REG_BYTE_OFS);
    assign wr_data = bus_wr && (bus_addr == REG_BYTE_DATA) && ind_ok;

    // ********************************
    // Read mux
    // ********************************
    always_comb begin
        case (bus_addr)
            REG_TBL_SEL:   rd_mux = sel_reg;
            REG_BYTE_OFS:  rd_mux = ofs_reg;
            REG_BYTE_DATA: rd_mux = cur_byte;
            default:       rd_mux = 8'h00;
        endcase
    end

    assign sel_next   = wr_sel ? bus_wdata : sel_reg;
    assign ofs_next   = wr_ofs ? bus_wdata : ofs_reg;
    assign rdata_next = bus_rd ? rd_mux : RDATA_RST;

    // ********************************
    // Direct registers
    // ********************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg   <= SEL_RST;
            ofs_reg   <= OFS_RST;
            rdata_reg <= RDATA_RST;
        end else begin
            sel_reg   <= sel_next;
            ofs_reg   <= ofs_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;

    // ********************************
    // Rule byte array
    // ********************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int b = 0; b < RULE_BYTES; b++) begin
                    rule_mem[p][b] <= RULE_RST;
                end
            end
        end else if (wr_data) begin
            rule_mem[port_idx][ofs_idx] <= wr_byte;
        end
    end

    // ********************************
    // Per-port field view and matching
    // ********************************
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        assign rule_out[g].rule_ip_address = {
            rule_mem[g][OFS_IP_MSB],
            rule_mem[g][OFS_IP_MSB + 4'h1],
            rule_mem[g][OFS_IP_MSB + 4'h2],
            rule_mem[g][OFS_IP_MSB + 4'h3]
        };
        assign rule_out[g].rule_ip_bitmask = {
            rule_mem[g][OFS_MSK_MSB],
            rule_mem[g][OFS_MSK_MSB + 4'h1],
            rule_mem[g][OFS_MSK_MSB + 4'h2],
            rule_mem[g][OFS_MSK_MSB + 4'h3]
        };
        assign rule_out[g].max_port = {
            rule_mem[g][OFS_MAX_HI],
            rule_mem[g][OFS_MAX_LO]
        };
        assign rule_out[g].min_port = {
            rule_mem[g][OFS_MIN_HI],
            rule_mem[g][OFS_MIN_LO]
        };
        assign rule_out[g].mode = arb_cmp_mode_t'(
            rule_mem[g][OFS_MODE][MODE_HI:MODE_LO]);
        assign rule_out[g].proto = {
            rule_mem[g][OFS_MODE][PROTO_TOP],
            rule_mem[g][OFS_PROTO][7:1]
        };
        assign rule_out[g].tcp_flag_match_enable =
            rule_mem[g][OFS_PROTO][FME_BIT];

        arb_match_unit u_match (
            .clk   (clk),
            .rst_n (rst_n),
            .rule  (rule_out[g]),
            .pkt   (pkt),
            .match (match_out[g])
        );
    end

    // ********************************
    // Checks
    // ********************************
    logic wr_port1;
    assign wr_port1 = wr_data && (port_num == PORT_FIRST);

    property p_tbl_gate;
        @(posedge clk) disable iff (!rst_n)
        (bus_rd && bus_addr == REG_BYTE_DATA && !tbl_hit)
            |=> (bus_rdata == 8'h00);
    endproperty
    a_tbl_gate: assert property (p_tbl_gate)
        else $error("data read outside the ACL table not zero");

    property p_port_range;
        @(posedge clk) disable iff (!rst_n)
        (bus_wr && bus_addr == REG_TBL_SEL &&
         bus_wdata[TBL_HI:TBL_LO] == TBL_ACL &&
         bus_wdata[PORT_HI:PORT_LO] > PORT_LAST)
            |=> !port_ok;
    endproperty
    a_port_range: assert property (p_port_range)
        else $error("port above five accepted");

    property p_max_hi;
        @(posedge clk) disable iff (!rst_n)
        (wr_port1 && ofs_idx == OFS_MAX_HI)
            |=> (rule_out[0].max_port[15:8] == $past(bus_wdata));
    endproperty
    a_max_hi: assert property (p_max_hi)
        else $error("offset 0x02 did not land in max bound high");

    property p_wr_rd;
        @(posedge clk) disable iff (!rst_n)
        (wr_data && ofs_idx != OFS_MODE) ##1
        (bus_rd && bus_addr == REG_BYTE_DATA && $stable(sel_reg) &&
         $stable(ofs_reg))
            |=> (bus_rdata == $past(bus_wdata, 2));
    endproperty
    a_wr_rd: assert property (p_wr_rd)
        else $error("data read did not return written byte");

    property p_mask_msb;
        @(posedge clk) disable iff (!rst_n)
        (wr_port1 && ofs_idx == OFS_MSK_MSB)
            |=> (rule_out[0].rule_ip_bitmask[31:24] == $past(bus_wdata));
    endproperty
    a_mask_msb: assert property (p_mask_msb)
        else $error("mask MSB not at offset 0x06");

    property p_min_lo;
        @(posedge clk) disable iff (!rst_n)
        (wr_port1 && ofs_idx == OFS_MIN_LO)
            |=> (rule_out[0].min_port[7:0] == $past(bus_wdata)) ##1
                ($stable(rule_out[0].min_port) || $past(wr_data));
    endproperty
    a_min_lo: assert property (p_min_lo)
        else $error("min bound low byte not held");

    property p_resv;
        @(posedge clk) disable iff (!rst_n)
        (bus_rd && bus_addr == REG_BYTE_DATA && ofs_reg == 8'h04)
            |=> (bus_rdata[7:3] == 5'h00);
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved bits of offset 0x04 not zero");

    property p_proto_lo;
        @(posedge clk) disable iff (!rst_n)
        (wr_port1 && ofs_idx == OFS_PROTO)
            |=> (rule_out[0].tcp_flag_match_enable == $past(bus_wdata[FME_BIT])) &&
                (rule_out[0].proto[6:0] == $past(bus_wdata[7:1]));
    endproperty
    a_proto_lo: assert property (p_proto_lo)
        else $error("offset 0x05 fields misplaced");

    property p_rd_idle;
        @(posedge clk) disable iff (!rst_n)
        !bus_rd
            |=> (bus_rdata == 8'h00);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside the read cycle");

    property p_ofs_gate;
        @(posedge clk) disable iff (!rst_n)
        (bus_rd && bus_addr == REG_BYTE_DATA && !ofs_ok)
            |=> (bus_rdata == 8'h00);
    endproperty
    a_ofs_gate: assert property (p_ofs_gate)
        else $error("data read beyond the rule bytes not zero");

    property p_port_gate;
        @(posedge clk) disable iff (!rst_n)
        (bus_rd && bus_addr == REG_BYTE_DATA && !port_ok)
            |=> (bus_rdata == 8'h00);
    endproperty
    a_port_gate: assert property (p_port_gate)
        else $error("data read for a port outside 1 to 5 not zero");

    property p_sel_rd;
        @(posedge clk) disable iff (!rst_n)
        (bus_rd && bus_addr == REG_TBL_SEL)
            |=> (bus_rdata == $past(sel_reg));
    endproperty
    a_sel_rd: assert property (p_sel_rd)
        else $error("table select read back wrong");

    property p_ofs_rd;
        @(posedge clk) disable iff (!rst_n)
        (bus_rd && bus_addr == REG_BYTE_OFS)
            |=> (bus_rdata == $past(ofs_reg));
    endproperty
    a_ofs_rd: assert property (p_ofs_rd)
        else $error("byte offset read back wrong");

    property p_no_wr;
        @(posedge clk) disable iff (!rst_n)
        !wr_data
            |=> $stable(rule_out);
    endproperty
    a_no_wr: assert property (p_no_wr)
        else $error("rule storage changed without an accepted write");

    property p_mode_field;
        @(posedge clk) disable iff (!rst_n)
        (wr_port1 && ofs_idx == OFS_MODE)
            |=> (rule_out[0].mode == $past(bus_wdata[MODE_HI:MODE_LO])) &&
                (rule_out[0].proto[7] == $past(bus_wdata[PROTO_TOP]));
    endproperty
    a_mode_field: assert property (p_mode_field)
        else $error("compare mode or protocol top bit misplaced");

    property p_resv_wr;
        @(posedge clk) disable iff (!rst_n)
        (wr_port1 && ofs_idx == OFS_MODE)
            |=> (rule_out[0].rule_ip_address[15:11] == 5'h00);
    endproperty
    a_resv_wr: assert property (p_resv_wr)
        else $error("reserved bits of offset 0x04 were stored");

endmodule : arb_bank
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the indirect ACL rule byte bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import arb_pkg::*;

    // ********************************
    // Signals and bookkeeping
    // ********************************
    logic                clk;
    logic                rst_n;
    logic [7:0]          bus_addr;
    logic [7:0]          bus_wdata;
    logic                bus_wr;
    logic                bus_rd;
    logic [7:0]          bus_rdata;
    arb_pkt_t            pkt;
    arb_rule_t [4:0]     rule_out;
    arb_match_t [4:0]    match_out;
    logic [7:0]          mem [1:5][0:15];
    logic [7:0]          exp_q [$];
    logic                rd_seen;
    logic [7:0]          d;
    int                  err_total;
    int                  checks_done;
    int                  cycles;
    int                  seed;

    arb_bank u_dut (
        .clk       (clk),
        .rst_n     (rst_n),
        .bus_addr  (bus_addr),
        .bus_wdata (bus_wdata),
        .bus_wr    (bus_wr),
        .bus_rd    (bus_rd),
        .bus_rdata (bus_rdata),
        .pkt       (pkt),
        .rule_out  (rule_out),
        .match_out (match_out)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus_addr  <= a;
        bus_wdata <= v;
        bus_wr    <= 1'b1;
        bus_rd    <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        bus_addr <= a;
        bus_wr   <= 1'b0;
        bus_rd   <= 1'b1;
        @(posedge clk);
    endtask : rd

    task automatic idle;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(posedge clk);
    endtask : idle

    task automatic sel(input int p, input logic [7:0] o);
        wr(REG_TBL_SEL, {TBL_ACL, 1'b0, 4'(p)});
        wr(REG_BYTE_OFS, o);
    endtask : sel

    task automatic chk_rule(input int p);
        arb_rule_t r;
        r = rule_out[p-1];
        check(r.rule_ip_address, {mem[p][2], mem[p][3], mem[p][4], mem[p][5]},
              "address");
        check(r.rule_ip_bitmask, {mem[p][6], mem[p][7], mem[p][8], mem[p][9]},
              "mask");
        check({r.max_port, r.min_port},
              {mem[p][2], mem[p][0], mem[p][1], mem[p][3]}, "bounds");
        check(32'(r.mode), 32'(mem[p][4][2:1]), "mode");
        check(32'(r.proto), 32'({mem[p][4][0], mem[p][5][7:1]}),
              "protocol");
        check(32'(r.tcp_flag_match_enable), 32'(mem[p][5][0]), "flag enable");
    endtask : chk_rule

    function automatic logic [1:0] exp_match(input int p, input arb_pkt_t k);
        logic [31:0] a;
        logic [31:0] m;
        logic [15:0] mx;
        logic [15:0] mn;
        logic        in_r;
        a    = {mem[p][2], mem[p][3], mem[p][4], mem[p][5]};
        m    = {mem[p][6], mem[p][7], mem[p][8], mem[p][9]};
        mx   = {mem[p][2], mem[p][0]};
        mn   = {mem[p][1], mem[p][3]};
        in_r = (k.l4_port >= mn) && (k.l4_port <= mx);
        exp_match[1] = ((k.ip ^ a) & m) == 32'h0;
        case (mem[p][4][2:1])
            2'h1:    exp_match[0] = (k.l4_port == mx) || (k.l4_port == mn);
            2'h2:    exp_match[0] = in_r;
            2'h3:    exp_match[0] = !in_r;
            default: exp_match[0] = 1'b0;
        endcase
    endfunction : exp_match

    // ********************************
    // Read data watcher and timeout
    // ********************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rd_seen <= 1'b0;
        else
            rd_seen <= bus_rd;
    end

    always @(negedge clk) begin
        if (rd_seen)
            check(bus_rdata, exp_q.pop_front(), "read data");
        else if (rst_n)
            check(bus_rdata, 8'h00, "idle read data");
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("ERROR at %0t: run timed out", $time);
            end_sim();
        end
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        seed = 53779;
        rst_n = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        pkt = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(REG_TBL_SEL, SEL_RST);
        rd(REG_BYTE_OFS, OFS_RST);
        for (int p = 1; p <= 5; p++)
            for (int o = 0; o < 16; o++) begin
                mem[p][o] = 8'h00;
                sel(p, 8'(o));
                rd(REG_BYTE_DATA, RULE_RST);
            end
        idle();
        @(negedge clk);
        for (int p = 1; p <= 5; p++)
            check(32'(match_out[p-1]), 32'h2, "reset match");
        $display("reset values test done");
        // Fill every byte of every port with random data, with the offset 0x04 mode bits set to the port number minus one, wrapping to 0 for port 5
        @(posedge clk);
        for (int p = 1; p <= 5; p++)
            for (int o = 0; o < 16; o++) begin
                d = 8'($random(seed));
                if (o == 4) d[2:1] = 2'(p - 1);
                sel(p, 8'(o));
                wr(REG_BYTE_DATA, d);
                mem[p][o] = (o == 4) ? (d & MODE_WMASK) : d;
            end
        for (int p = 1; p <= 5; p++)
            for (int o = 0; o < 16; o++) begin
                sel(p, 8'(o));
                rd(REG_BYTE_DATA, mem[p][o]);
            end
        idle();
        for (int p = 1; p <= 5; p++)
            chk_rule(p);
        $display("fill and read back test done");
        // Refused accesses leave storage untouched
        wr(REG_TBL_SEL, {3'h3, 1'b0, 4'h1});
        wr(REG_BYTE_OFS, 8'h00);
        wr(REG_BYTE_DATA, ~mem[1][0]);
        rd(REG_BYTE_DATA, 8'h00);
        wr(REG_TBL_SEL, {TBL_ACL, 1'b0, 4'h0});
        wr(REG_BYTE_DATA, ~mem[1][0]);
        rd(REG_BYTE_DATA, 8'h00);
        wr(REG_TBL_SEL, {TBL_ACL, 1'b0, 4'h6});
        rd(REG_TBL_SEL, {TBL_ACL, 1'b0, 4'h6});
        rd(REG_BYTE_DATA, 8'h00);
        sel(1, 8'h10);
        rd(REG_BYTE_DATA, 8'h00);
        rd(8'h55, 8'h00);
        sel(1, 8'h00);
        rd(REG_BYTE_DATA, mem[1][0]);
        d = 8'($random(seed));
        sel(2, 8'h0a);
        wr(REG_BYTE_DATA, d);
        rd(REG_BYTE_DATA, d);
        mem[2][10] = d;
        idle();
        chk_rule(1);
        $display("refused access test done");
        // Packets aimed at each port's address and bounds
        for (int t = 0; t < 60; t++) begin
            automatic int q = (t % 5) + 1;
            automatic arb_pkt_t k;
            k.ip = 32'($random(seed));
            if (t[1])
                k.ip = rule_out[q-1].rule_ip_address ^ (k.ip & ~rule_out[q-1].rule_ip_bitmask);
            case ((t / 5) % 4)
                0:       k.l4_port = {mem[q][2], mem[q][0]};
                1:       k.l4_port = {mem[q][1], mem[q][3]};
                2:       k.l4_port = 16'($random(seed));
                default: k.l4_port = {mem[q][1], mem[q][3]} + 16'h1;
            endcase
            pkt <= k;
            @(posedge clk);
            @(posedge clk);
            @(negedge clk);
            for (int p = 1; p <= 5; p++)
                check(32'(match_out[p-1]), 32'(exp_match(p, k)),
                      "match");
            @(posedge clk);
        end
        $display("match test done");
        end_sim();
    end

endmodule : tb_top
`default_nettype wire
